// ===== logic/dual_codec_serial_port_defs.vh
// Constants for the dual channel codec serial port.
// Assumes inclusion by bare name from the design file.
`ifndef DUAL_CODEC_SERIAL_PORT_DEFS_VH
`define DUAL_CODEC_SERIAL_PORT_DEFS_VH
// ----------------------------------------
// Port addresses and data layout
// ----------------------------------------
`define PORT_CTRL0 3'h0
`define PORT_DATA1 3'h1
`define CTRL0_RESET 16'h0000
`define CTRL1_RESET 16'h0000
// Control 0 fields
`define C0_BCLK_DRIVE 0
`define C0_MULAW 1
`define C0_COMP_EN 2
`define C0_RXIRQ_EN 3
// Port 1 routing sits in control 0 so control 1 stays reachable
`define C0_SEL_CTRL1 4
// Control 1 fields: channel select for data port
`define C1_CH_B 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_CLK_HZ 20000000
`define BCLK_HALF_NS 200
`define BCLK_HALF_CYC ((`BCLK_HALF_NS * (`CORE_CLK_HZ / 1000000)) / 1000)
`define WORD_BITS 8
`endif

// ===== logic/dual_codec_serial_port.v
// Dual channel framed serial port with companding on the data path.
// Assumes a processor-side I/O strobe on the core clock and a codec or
// microcontroller on the far side; link pins are asynchronous.
// Functional notes
// - Port 0 reaches control register zero
// - Port 1 reaches control one and data
// - Other six port addresses left unused here
// - Mu-law and A-law encode, decode on data
// - Eight bit words timed by frame pulse
// - Bit clock, data pin, frame pin per transfer
// - Frame request output for link arbitration
// - Load strobe copies transmit hold to shift
// - Receive strobe copies shift to hold
// - Bit clock pin driven or received
// - Data pins face the shift registers
// - Interrupt when receive frame returns high
`timescale 1ns/100ps
`include "dual_codec_serial_port_defs.vh"
module dual_codec_serial_port
#(
  parameter BCLK_HALF = `BCLK_HALF_CYC
)
(
  input wire i_core_clk, // Core clock, 20 MHz
  input wire i_nrst, // Synchronous reset, active low
  input wire [2:0] i_port_addr, // I/O port address
  input wire i_port_wr, // Write strobe
  input wire i_port_rd, // Read strobe
  input wire [15:0] i_port_wdata, // Write data
  output reg [15:0] o_port_rdata, // Read data
  input wire i_bclk, // Bit clock pin input
  output reg o_bclk, // Bit clock pin output
  output reg o_bclk_oe, // Bit clock pin enable
  input wire i_frame_sync_in_rx, // Receive frame, active low
  input wire i_frame_sync_in_tx, // Transmit frame, active low
  input wire i_ser_in_ch_a, // Receive data channel a
  input wire i_ser_in_ch_b, // Receive data channel b
  output reg o_ser_out_ch_a, // Transmit data channel a
  output reg o_ser_out_ch_b, // Transmit data channel b
  output reg o_frame_request_out, // Frame request, active low
  output reg o_rx_irq // Receive done pulse
);
  // ----------------------------------------
  // Companding functions
  // ----------------------------------------
  // Linear sample to 8-bit code; 13-bit magnitude for mu-law, 12-bit magnitude for A-law
  function [7:0] encode;
    input [15:0] s;
    input mu;
    reg sg;
    reg [14:0] m;
    reg [2:0] e;
    reg [3:0] q;
    integer k;
    begin
      sg = s[15];
      m = sg ? (~s[14:0] + 15'h0001) : s[14:0];
      if (mu)
        m = (m > 15'h1F5F) ? 15'h1FFF : (m + 15'h0021);
      e = 3'h0;
      // Mu-law segments start one bit higher, past the bias
      for (k = 1; k < 8; k = k + 1)
        if (mu ? m[k+5] : m[k+4])
          e = k[2:0];
      if (mu)
        q = m[e+4 -: 4];
      else
        q = (e == 3'h0) ? m[4:1] : m[e+3 -: 4];
      encode = {sg, e, q} ^ (mu ? 8'hFF : 8'hD5);
    end
  endfunction
  // 8-bit code back to linear sample
  function [15:0] decode;
    input [7:0] c;
    input mu;
    reg [7:0] u;
    reg [14:0] m;
    begin
      u = c ^ (mu ? 8'hFF : 8'hD5);
      // Rebuild at mid-step of the segment to halve the error
      m = {10'h000, 1'b1, u[3:0]} << u[6:4];
      if (mu)
        m = (m << 1) + ({14'h0000, 1'b1} << u[6:4]) - 15'h0021;
      else if (u[6:4] == 3'h0)
        m = {10'h000, u[3:0], 1'b1};
      else
        m = m + ({14'h0000, 1'b1} << (u[6:4] - 3'h1));
      decode = u[7] ? (~{1'b0, m} + 16'h0001) : {1'b0, m};
    end
  endfunction
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] bclk_s_r, fsr_s_r, fsx_s_r, dra_s_r, drb_s_r;
  reg bclk_prev_r;
  // Two stages per pin; only stage two is read by logic
  always @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      bclk_s_r <= 2'h0;
      fsr_s_r <= 2'h3;
      fsx_s_r <= 2'h3;
      dra_s_r <= 2'h0;
      drb_s_r <= 2'h0;
      bclk_prev_r <= 1'b0;
    end
    else
    begin
      bclk_s_r <= {bclk_s_r[0], o_bclk_oe ? o_bclk : i_bclk};
      fsr_s_r <= {fsr_s_r[0], i_frame_sync_in_rx};
      fsx_s_r <= {fsx_s_r[0], i_frame_sync_in_tx};
      dra_s_r <= {dra_s_r[0], i_ser_in_ch_a};
      drb_s_r <= {drb_s_r[0], i_ser_in_ch_b};
      bclk_prev_r <= bclk_s_r[1];
    end
  end
  wire bclk_rise = bclk_s_r[1] & ~bclk_prev_r;
  wire bclk_fall = ~bclk_s_r[1] & bclk_prev_r;
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [15:0] ctrl0_r, ctrl1_r;
  reg [7:0] xmit_hold_ch_a, xmit_hold_ch_b;
  reg [7:0] xmit_shift_ch_a, xmit_shift_ch_b;
  reg [7:0] recv_shift_ch_a, recv_shift_ch_b;
  reg [7:0] recv_hold_ch_a, recv_hold_ch_b;
  reg [3:0] tx_cnt_r, rx_cnt_r;
  reg rx_full_r, fsr_prev_r;
  reg [15:0] div_r;
  wire mu = ctrl0_r[`C0_MULAW];
  wire comp = ctrl0_r[`C0_COMP_EN];
  wire chb = ctrl1_r[`C1_CH_B];
  wire tx_act = ~fsx_s_r[1];
  wire rx_act = ~fsr_s_r[1];
  // Load strobe: frame start with idle counter
  wire xmit_shift_load = tx_act & bclk_rise & (tx_cnt_r == 4'h0);
  // Extra falling edge after the frame release that follows the eighth bit moves shift into hold
  wire rx_load = bclk_fall & rx_full_r;
  wire [7:0] wr_code = comp ? encode(i_port_wdata, mu) : i_port_wdata[7:0];
  wire wr_data = i_port_wr & (i_port_addr == `PORT_DATA1)
    & ~ctrl0_r[`C0_SEL_CTRL1];
  // Main datapath
  always @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      ctrl0_r <= `CTRL0_RESET;
      ctrl1_r <= `CTRL1_RESET;
      xmit_hold_ch_a <= 8'h00;
      xmit_hold_ch_b <= 8'h00;
      xmit_shift_ch_a <= 8'h00;
      xmit_shift_ch_b <= 8'h00;
      recv_shift_ch_a <= 8'h00;
      recv_shift_ch_b <= 8'h00;
      recv_hold_ch_a <= 8'h00;
      recv_hold_ch_b <= 8'h00;
      tx_cnt_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_full_r <= 1'b0;
      fsr_prev_r <= 1'b1;
      o_rx_irq <= 1'b0;
      o_frame_request_out <= 1'b1;
    end
    else
    begin
      // Port writes; addresses 2..7 are left for parallel I/O
      if (i_port_wr && i_port_addr == `PORT_CTRL0)
        ctrl0_r <= i_port_wdata;
      if (i_port_wr && i_port_addr == `PORT_DATA1 &&
          ctrl0_r[`C0_SEL_CTRL1])
        ctrl1_r <= i_port_wdata;
      if (wr_data && !chb)
        xmit_hold_ch_a <= wr_code;
      if (wr_data && chb)
        xmit_hold_ch_b <= wr_code;
      // Frame request held until the transmit frame starts
      if (wr_data)
        o_frame_request_out <= 1'b0;
      else if (xmit_shift_load)
        o_frame_request_out <= 1'b1;
      // Transmit shifting, msb first
      if (xmit_shift_load)
      begin
        xmit_shift_ch_a <= xmit_hold_ch_a;
        xmit_shift_ch_b <= xmit_hold_ch_b;
        tx_cnt_r <= 4'h1;
      end
      else if (bclk_rise && tx_cnt_r != 4'h0)
      begin
        xmit_shift_ch_a <= {xmit_shift_ch_a[6:0], 1'b0};
        xmit_shift_ch_b <= {xmit_shift_ch_b[6:0], 1'b0};
        tx_cnt_r <= (tx_cnt_r == `WORD_BITS) ? 4'h0 : tx_cnt_r + 4'h1;
      end
      // Receive shifting on falling edge within frame
      if (rx_act && bclk_fall && rx_cnt_r != `WORD_BITS)
      begin
        recv_shift_ch_a <= {recv_shift_ch_a[6:0], dra_s_r[1]};
        recv_shift_ch_b <= {recv_shift_ch_b[6:0], drb_s_r[1]};
        rx_cnt_r <= rx_cnt_r + 4'h1;
      end
      if (rx_load)
      begin
        recv_hold_ch_a <= recv_shift_ch_a;
        recv_hold_ch_b <= recv_shift_ch_b;
        rx_full_r <= 1'b0;
      end
      // Frame release ends the word and flags it
      fsr_prev_r <= fsr_s_r[1];
      o_rx_irq <= 1'b0;
      if (fsr_s_r[1] && !fsr_prev_r)
      begin
        o_rx_irq <= ctrl0_r[`C0_RXIRQ_EN] & (rx_cnt_r == `WORD_BITS);
        rx_full_r <= (rx_cnt_r == `WORD_BITS);
        rx_cnt_r <= 4'h0;
      end
    end
  end
  // ----------------------------------------
  // Outputs and bit clock generator
  // ----------------------------------------
  // Internal bit clock; divider runs whether or not the pin is driven
  always @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      div_r <= 16'h0000;
      o_bclk <= 1'b0;
      o_bclk_oe <= 1'b0;
      o_ser_out_ch_a <= 1'b0;
      o_ser_out_ch_b <= 1'b0;
      o_port_rdata <= 16'h0000;
    end
    else
    begin
      o_bclk_oe <= ctrl0_r[`C0_BCLK_DRIVE];
      if (div_r >= BCLK_HALF - 1)
      begin
        div_r <= 16'h0000;
        o_bclk <= ~o_bclk;
      end
      else
        div_r <= div_r + 16'h0001;
      o_ser_out_ch_a <= xmit_shift_ch_a[7];
      o_ser_out_ch_b <= xmit_shift_ch_b[7];
      if (i_port_rd && i_port_addr == `PORT_CTRL0)
        o_port_rdata <= ctrl0_r;
      else if (i_port_rd && i_port_addr == `PORT_DATA1)
      begin
        if (ctrl0_r[`C0_SEL_CTRL1])
          o_port_rdata <= ctrl1_r;
        else if (comp)
          o_port_rdata <= decode(chb ? recv_hold_ch_b : recv_hold_ch_a, mu);
        else
          o_port_rdata <= {8'h00, chb ? recv_hold_ch_b : recv_hold_ch_a};
      end
      else
        o_port_rdata <= 16'h0000;
    end
  end
endmodule

// ===== testbench/dual_codec_serial_port_assertions.sv
// Checker for the dual codec serial port core.
// Assumes it is bound to that module and sees its ports only.
`timescale 1ns/100ps
module port_chk
#(
  parameter int BCLK_HALF = 4
)
(
  input wire i_core_clk, // Clock
  input wire i_nrst, // Reset, low
  input wire [2:0] i_port_addr, // Addr
  input wire i_port_wr, // Write
  input wire i_port_rd, // Read
  input wire [15:0] i_port_wdata, // Wdata
  input wire [15:0] o_port_rdata, // Rdata
  input wire i_bclk, // Bclk in
  input wire o_bclk, // Bclk out
  input wire o_bclk_oe, // Bclk enable
  input wire i_frame_sync_in_rx, // Rx frame
  input wire i_frame_sync_in_tx, // Tx frame
  input wire i_ser_in_ch_a, // Rx a
  input wire i_ser_in_ch_b, // Rx b
  input wire o_ser_out_ch_a, // Tx a
  input wire o_ser_out_ch_b, // Tx b
  input wire o_frame_request_out, // Frame req
  input wire o_rx_irq // Irq
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // Read data only stands after a read, unmapped reads give zero
  property p_rd_idle;
    !i_port_rd |=> o_port_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rd_unmapped;
    i_port_rd && i_port_addr > 3'h1 |=> o_port_rdata == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");
  // Request falls only on a data write, rises only inside a frame
  property p_fr_fall;
    $fell(o_frame_request_out) |-> $past(i_port_wr && i_port_addr == 3'h1);
  endproperty
  a_fr_fall: assert property (p_fr_fall) else $error("req fell");
  property p_fr_rise;
    $rose(o_frame_request_out) |-> !i_frame_sync_in_tx;
  endproperty
  a_fr_rise: assert property (p_fr_rise) else $error("req rose");
  // Drive enable follows control zero
  property p_oe;
    i_port_wr && i_port_addr == 3'h0 && i_port_wdata[0] |-> ##[1:2] o_bclk_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("bclk enable");
  // Irq is a single pulse seen only once the frame is back high
  sequence s_irq;
    o_rx_irq;
  endsequence
  property p_irq_pulse;
    s_irq |=> !o_rx_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq width");
  property p_irq_frame;
    s_irq |-> i_frame_sync_in_rx && $past(i_frame_sync_in_rx);
  endproperty
  a_irq_frame: assert property (p_irq_frame) else $error("irq early");
  // Driven clock never toggles two cycles running
  property p_bclk;
    o_bclk_oe && $changed(o_bclk) |=> $stable(o_bclk);
  endproperty
  a_bclk: assert property (p_bclk) else $error("bclk rate");
endmodule
bind dual_codec_serial_port port_chk #(.BCLK_HALF(BCLK_HALF)) u_chk (.*);

// ===== testbench/codec_model.sv
// Behavioural codec on the far side of the serial link.
// Assumes the bench pulses i_go; its clock runs inside a frame, plus one pulse after release.
`timescale 1ns/100ps
module codec_model
(
  input wire i_go, // Start one word
  input wire [7:0] i_tx, // Word to device
  input wire i_dev_sd, // Device data out
  output logic o_bclk = 1'b0, // Gated bit clock
  output logic o_fs_n = 1'b1, // Frame, active low
  output logic o_sd = 1'b0, // Data to device
  output logic [7:0] o_rx = 8'h00, // Word from device
  output logic o_busy = 1'b0 // Word in progress
);
  // Data moves on rising edges; device output sampled late, it lags
  always @(posedge i_go)
  begin
    o_busy = 1'b1;
    o_fs_n = 1'b0;
    #200;
    for (int k = 7; k >= 0; k--)
    begin
      o_bclk = 1'b1;
      o_sd = i_tx[k];
      #200;
      o_bclk = 1'b0;
      #150;
      o_rx[k] = i_dev_sd;
      #50;
    end
    o_fs_n = 1'b1;
    o_sd = ~o_sd; // Released line shows no stale bit
    #400;
    o_bclk = 1'b1;
    #200;
    o_bclk = 1'b0;
    #400;
    o_busy = 1'b0;
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the dual codec serial port.
// Assumes the codec model as far side and the bound checker.
`timescale 1ns/100ps
module tb;
  logic i_core_clk = 0, i_nrst = 0, i_port_wr = 0, i_port_rd = 0, go = 0;
  logic selb = 0, pb = 0;
  logic [2:0] i_port_addr = 3'h0;
  logic [15:0] i_port_wdata = 16'h0000, v;
  logic [7:0] tx = 8'h00;
  wire [15:0] o_port_rdata;
  wire [7:0] rx;
  wire o_bclk, oe, fs_n, sd, busy, ser_a, ser_b, frq, irq, m_bclk;
  wire bclk = oe ? o_bclk : m_bclk;
  int n_fail = 0, num_checks = 0, n_irq = 0, n;
  dual_codec_serial_port #(.BCLK_HALF(2)) DUT (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .i_port_addr(i_port_addr), .i_port_wr(i_port_wr),
    .i_port_rd(i_port_rd), .i_port_wdata(i_port_wdata),
    .o_port_rdata(o_port_rdata), .i_bclk(bclk), .o_bclk(o_bclk),
    .o_bclk_oe(oe), .i_frame_sync_in_rx(fs_n), .i_frame_sync_in_tx(fs_n),
    .i_ser_in_ch_a(sd), .i_ser_in_ch_b(~sd), .o_ser_out_ch_a(ser_a),
    .o_ser_out_ch_b(ser_b), .o_frame_request_out(frq), .o_rx_irq(irq));
  codec_model u_codec (.i_go(go), .i_tx(tx),
    .i_dev_sd(selb ? ser_b : ser_a),
    .o_bclk(m_bclk), .o_fs_n(fs_n), .o_sd(sd), .o_rx(rx), .o_busy(busy));
  // Clock, irq pulse counter
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (irq === 1'b1) n_irq++;
  task chk(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_core_clk) #1;
    i_port_addr = a;
    i_port_wdata = d;
    i_port_wr = 1;
    @(posedge i_core_clk) #1;
    i_port_wr = 0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge i_core_clk) #1;
    i_port_addr = a;
    i_port_rd = 1;
    @(posedge i_core_clk) #1;
    i_port_rd = 0;
    v = o_port_rdata;
  endtask
  // One framed word; bounded wait on the model
  task xfer(input logic [7:0] t, input logic [15:0] d);
    wr(3'h1, d);
    chk("req low", frq, 16'h0000);
    tx = t;
    go = 1;
    n_irq = 0;
    @(posedge i_core_clk) #1;
    for (int k = 0; k < 400 && busy === 1'b1; k++) @(posedge i_core_clk);
    chk("busy", busy, 16'h0000);
    #1 go = 0;
    chk("req high", frq, 16'h0001);
  endtask
  task t_reset;
    chk("req", frq, 16'h0001); // RESET
    chk("oe", oe, 16'h0000); // RESET
    chk("rdata", o_port_rdata, 16'h0000); // RESET
    for (int a = 2; a < 8; a++)
    begin
      wr(a[2:0], 16'hFFFF);
      rd(a[2:0]);
      chk("unmapped", v, 16'h0000);
    end
    chk("req idle", frq, 16'h0001);
    $display("test reset done");
  endtask
  task t_words;
    wr(3'h0, 16'h0008);
    xfer(8'h3C, 16'h00A5);
    chk("tx a", rx, 16'h00A5);
    chk("irq", n_irq[15:0], 16'h0001);
    rd(3'h1);
    chk("rx a", v[7:0], 16'h003C);
    wr(3'h0, 16'h0000);
    xfer(8'hC3, 16'h005A);
    chk("tx a2", rx, 16'h005A);
    chk("irq off", n_irq[15:0], 16'h0000);
    $display("test words done");
  endtask
  task t_compand;
    wr(3'h0, 16'h0006);
    xfer(8'hFF, 16'h0000);
    chk("mu enc", rx, 16'h00FF);
    rd(3'h1);
    chk("mu dec", v, 16'h0000);
    wr(3'h0, 16'h0004);
    xfer(8'hD5, 16'h0000);
    chk("a enc", rx, 16'h00D5);
    $display("test compand done");
  endtask
  // Control 1 through the routing bit, then a word on channel b
  task t_chan_b;
    wr(3'h0, 16'h0010);
    wr(3'h1, 16'h0001);
    rd(3'h1);
    chk("ctrl1", v, 16'h0001);
    chk("req kept", frq, 16'h0001);
    rd(3'h0);
    chk("ctrl0", v, 16'h0010);
    wr(3'h0, 16'h0000);
    selb = 1;
    xfer(8'h96, 16'h00E1);
    chk("tx b", rx, 16'h00E1);
    rd(3'h1);
    chk("rx b", v, 16'h0069);
    selb = 0;
    $display("test channel b done");
  endtask
  task t_bclk;
    wr(3'h0, 16'h0001);
    repeat (3) @(posedge i_core_clk);
    #1 chk("drive", oe, 16'h0001);
    n = 0;
    pb = o_bclk;
    repeat (40)
    begin
      @(posedge i_core_clk) #1;
      if (o_bclk !== pb)
        n++;
      pb = o_bclk;
    end
    chk("toggles", n[15:0], 16'd20);
    wr(3'h0, 16'h0000);
    repeat (3) @(posedge i_core_clk);
    #1 chk("release", oe, 16'h0000);
    $display("test bclk done");
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence, then a watchdog well beyond its length
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    #1 i_nrst = 1;
    t_reset;
    t_words;
    t_compand;
    t_chan_b;
    t_bclk;
    wrap_up;
  end
  initial
  begin
    #2000000;
    n_fail++;
    wrap_up;
  end
endmodule
